//--- etp_encoder.sv
// Exception trace packet encoder, 32-bit halfword-aligned address form
`timescale 1ns/1ns
`include "etp_consts.svh"
module etp_encoder
  import etp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic req_valid,
  input wire etp_req_t req,
  output logic req_ready,
  output logic out_valid,
  output logic [7:0] out_data,
  input wire logic out_ready,
  output logic busy,
  output logic reject,
  output logic [31:0] hist_entry0,
  output logic [31:0] last_process_tag,
  output logic [31:0] last_vm_tag
);

  etp_state_t state_r;
  etp_state_t state_nxt;
  etp_pkt_t pkt_r;
  etp_pkt_t pkt_nxt;
  logic [3:0] idx_r;
  logic [3:0] idx_nxt;
  logic req_ready_r;
  logic out_valid_r;
  logic [7:0] out_data_r;
  logic [7:0] out_data_nxt;
  logic busy_r;
  logic reject_r;
  logic [31:0] hist_r;
  logic [31:0] hist_nxt;
  logic [31:0] last_ctx_r;
  logic [31:0] last_ctx_nxt;
  logic [31:0] last_vm_r;
  logic [31:0] last_vm_nxt;
  logic pend_ctx_r;
  logic pend_vm_r;
  logic [31:0] pend_ctx_val_r;
  logic [31:0] pend_vm_val_r;
  logic [7:0] sel_byte;

  // Request decode
  wire take = ce & req_valid & req_ready_r;

  wire [4:0] ty = req.exc_type;
  wire ty_impl = (ty >= `ETP_TYPE_IMPL_LO) && (ty <= `ETP_TYPE_IMPL_HI);
  wire ty_base_a = (ty == `ETP_TYPE_RESET) || (ty == `ETP_TYPE_HALT);
  wire ty_base_b = (ty == `ETP_TYPE_CALL) || (ty == `ETP_TYPE_TRAP);
  wire ty_base_c = (ty == `ETP_TYPE_SERR);
  wire ty_dbg = (ty == `ETP_TYPE_IDBG) || (ty == `ETP_TYPE_DDBG);
  wire ty_flt_a = (ty == `ETP_TYPE_ALIGN) || (ty == `ETP_TYPE_IFLT);
  wire ty_flt_b = (ty == `ETP_TYPE_DFLT);
  wire ty_irq = (ty == `ETP_TYPE_IRQ) || (ty == `ETP_TYPE_FAST_IRQ);
  wire ty_std = ty_dbg | ty_flt_a | ty_flt_b | ty_irq;
  wire ty_base = ty_base_a | ty_base_b | ty_base_c;
  // Transaction-failure code and gaps fall out here
  wire type_ok = ty_base | ty_std | ty_impl;

  wire esel_ok = (req.elem_sel == `ETP_ESEL_CTX_EXC) ||
                 (req.elem_sel == `ETP_ESEL_TGT_CTX_EXC);
  wire req_ok = type_ok & esel_ok;

  // Tag selection
  wire use_ctx = req.send_process_tag;
  wire use_vm = req.send_vm_tag;
  // Disabled tracing still honours the variant but zeroes the value
  wire [31:0] ctx_val = req.process_tag_trace_en ?
                        req.process_tag : `ETP_RST_WORD;
  wire [31:0] vm_val = req.vm_tag_trace_en ?
                       req.virtual_machine_tag : `ETP_RST_WORD;

  wire [1:0] info_top = (use_ctx & use_vm) ? `ETP_INFO_BOTH :
                        use_ctx ? `ETP_INFO_CTX :
                        use_vm ? `ETP_INFO_VM :
                        `ETP_INFO_NONE;

  wire [7:0] info_byte = {info_top,
                          req.security_state_bit,
                          req.execution_width_bit,
                          2'b00,
                          req.exception_level};

  wire [7:0] type_byte = {1'b0, req.elem_sel[1], ty,
                          req.elem_sel[0]};

  // Machine tag goes first when both are present
  wire [31:0] tag_first = use_vm ? vm_val : ctx_val;
  wire [31:0] tag_second = ctx_val;

  wire [1:0] tag_count = {1'b0, use_ctx} + {1'b0, use_vm};
  wire [4:0] pkt_len = `ETP_LEN_BASE +
                       5'(`ETP_TAG_BYTES * {3'h0, tag_count});
  wire [3:0] last_idx = 4'(pkt_len - 5'h01);

  // Address with bit 0 cleared before it is replaced into history
  wire [31:0] addr_aligned = {req.ret_addr[31:1], 1'b0};

  always_comb begin
    pkt_nxt.type_byte = type_byte;
    pkt_nxt.ret_addr = addr_aligned;
    pkt_nxt.info_byte = info_byte;
    pkt_nxt.tag_first = tag_first;
    pkt_nxt.tag_second = tag_second;
    pkt_nxt.last_idx = last_idx;
  end

  // Byte stream
  wire beat = ce & out_valid_r & out_ready;
  wire last_beat = beat & (idx_r == pkt_r.last_idx);
  wire [3:0] idx_inc = idx_r + 4'h1;

  etp_byte_sel u_sel (
    .pkt(pkt_r),
    .idx(idx_inc),
    .byte_out(sel_byte)
  );

  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    out_data_nxt = out_data_r;
    case (state_r)
      ETP_IDLE: begin
        if (take && req_ok) begin
          state_nxt = ETP_SEND;
          idx_nxt = `ETP_IDX_HDR;
          out_data_nxt = `ETP_HDR_BYTE;
        end
      end
      ETP_SEND: begin
        if (last_beat) begin
          state_nxt = ETP_IDLE;
        end else if (beat) begin
          idx_nxt = idx_inc;
          out_data_nxt = sel_byte;
        end
      end
      default: begin
        state_nxt = ETP_IDLE;
      end
    endcase
  end

  // Decoder-visible state moves only once the packet has fully left
  always_comb begin
    hist_nxt = hist_r;
    last_ctx_nxt = last_ctx_r;
    last_vm_nxt = last_vm_r;
    if (last_beat) begin
      hist_nxt = pkt_r.ret_addr;
      if (pend_ctx_r) begin
        last_ctx_nxt = pend_ctx_val_r;
      end
      if (pend_vm_r) begin
        last_vm_nxt = pend_vm_val_r;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ETP_IDLE;
      idx_r <= `ETP_IDX_HDR;
      out_data_r <= `ETP_RST_BYTE;
    end else if (ce) begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      out_data_r <= out_data_nxt;
    end
  end

  // Handshake flags
  always_ff @(posedge clk) begin
    if (rst) begin
      req_ready_r <= 1'b0;
      out_valid_r <= 1'b0;
      busy_r <= 1'b0;
    end else if (ce) begin
      req_ready_r <= (state_nxt == ETP_IDLE);
      out_valid_r <= (state_nxt == ETP_SEND);
      busy_r <= (state_nxt == ETP_SEND);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reject_r <= 1'b0;
    end else if (ce) begin
      reject_r <= take & ~req_ok;
    end
  end

  // Packet capture
  always_ff @(posedge clk) begin
    if (rst) begin
      pkt_r <= '0;
      pend_ctx_r <= 1'b0;
      pend_vm_r <= 1'b0;
      pend_ctx_val_r <= `ETP_RST_WORD;
      pend_vm_val_r <= `ETP_RST_WORD;
    end else if (ce && take && req_ok) begin
      pkt_r <= pkt_nxt;
      pend_ctx_r <= use_ctx;
      pend_vm_r <= use_vm;
      pend_ctx_val_r <= ctx_val;
      pend_vm_val_r <= vm_val;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hist_r <= `ETP_RST_WORD;
      last_ctx_r <= `ETP_RST_WORD;
      last_vm_r <= `ETP_RST_WORD;
    end else if (ce) begin
      hist_r <= hist_nxt;
      last_ctx_r <= last_ctx_nxt;
      last_vm_r <= last_vm_nxt;
    end
  end

  assign req_ready = req_ready_r;
  assign out_valid = out_valid_r;
  assign out_data = out_data_r;
  assign busy = busy_r;
  assign reject = reject_r;
  assign hist_entry0 = hist_r;
  assign last_process_tag = last_ctx_r;
  assign last_vm_tag = last_vm_r;

endmodule

//--- etp_consts.svh
// Constants of the exception trace packet encoder
`ifndef ETP_CONSTS_SVH
`define ETP_CONSTS_SVH
`define ETP_HDR_BYTE 8'h06
`define ETP_ADDR_KIND 8'h83
`define ETP_INFO_NONE 2'h0
`define ETP_INFO_CTX 2'h2
`define ETP_INFO_VM 2'h1
`define ETP_INFO_BOTH 2'h3
`define ETP_ESEL_CTX_EXC 2'h1
`define ETP_ESEL_TGT_CTX_EXC 2'h2
`define ETP_TYPE_RESET 5'h00
`define ETP_TYPE_HALT 5'h01
`define ETP_TYPE_CALL 5'h02
`define ETP_TYPE_TRAP 5'h03
`define ETP_TYPE_SERR 5'h04
`define ETP_TYPE_IDBG 5'h06
`define ETP_TYPE_DDBG 5'h07
`define ETP_TYPE_ALIGN 5'h0A
`define ETP_TYPE_IFLT 5'h0B
`define ETP_TYPE_DFLT 5'h0C
`define ETP_TYPE_IRQ 5'h0E
`define ETP_TYPE_FAST_IRQ 5'h0F
`define ETP_TYPE_IMPL_LO 5'h10
`define ETP_TYPE_IMPL_HI 5'h17
`define ETP_IDX_HDR 4'h0
`define ETP_IDX_TYPE 4'h1
`define ETP_IDX_KIND 4'h2
`define ETP_IDX_A0 4'h3
`define ETP_IDX_A1 4'h4
`define ETP_IDX_A2 4'h5
`define ETP_IDX_A3 4'h6
`define ETP_IDX_INFO 4'h7
`define ETP_LEN_BASE 5'h08
`define ETP_TAG_BYTES 5'h04
`define ETP_RST_WORD 32'h0000_0000
`define ETP_RST_BYTE 8'h00
`endif

//--- etp_pkg.sv
// Types shared by the exception trace packet encoder
package etp_pkg;

  typedef enum logic {
    ETP_IDLE,
    ETP_SEND
  } etp_state_t;

  // One exception as offered by the trace unit
  typedef struct packed {
    logic [4:0] exc_type;
    logic [1:0] elem_sel;
    logic [1:0] exception_level;
    logic security_state_bit;
    logic execution_width_bit;
    logic [31:0] ret_addr;
    logic [31:0] process_tag;
    logic [31:0] virtual_machine_tag;
    logic send_process_tag;
    logic send_vm_tag;
    logic process_tag_trace_en;
    logic vm_tag_trace_en;
  } etp_req_t;

  // Captured packet contents
  typedef struct packed {
    logic [7:0] type_byte;
    logic [31:0] ret_addr;
    logic [7:0] info_byte;
    logic [31:0] tag_first;
    logic [31:0] tag_second;
    logic [3:0] last_idx;
  } etp_pkt_t;

endpackage

//--- etp_byte_sel.sv
// Picks one packet byte by its position
`timescale 1ns/1ns
`include "etp_consts.svh"
module etp_byte_sel
  import etp_pkg::*;
(
  input wire etp_pkt_t pkt,
  input wire logic [3:0] idx,
  output logic [7:0] byte_out
);

  wire [1:0] lane = idx[1:0];
  wire [31:0] tag_word = idx[2] ? pkt.tag_second : pkt.tag_first;
  wire [7:0] tag_byte = tag_word[{lane, 3'h0} +: 8];

  always_comb begin
    case (idx)
      `ETP_IDX_HDR: byte_out = `ETP_HDR_BYTE;
      `ETP_IDX_TYPE: byte_out = pkt.type_byte;
      `ETP_IDX_KIND: byte_out = `ETP_ADDR_KIND;
      `ETP_IDX_A0: byte_out = {1'b0, pkt.ret_addr[7:1]};
      `ETP_IDX_A1: byte_out = pkt.ret_addr[15:8];
      `ETP_IDX_A2: byte_out = pkt.ret_addr[23:16];
      `ETP_IDX_A3: byte_out = pkt.ret_addr[31:24];
      `ETP_IDX_INFO: byte_out = pkt.info_byte;
      // Tag bytes 8..15, least significant first
      default: byte_out = tag_byte;
    endcase
  end

endmodule

//--- etp_encoder_monitor.sv
// Port assertions for the exception trace packet encoder
`timescale 1ns/1ns
module etp_monitor
  import etp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic req_valid,
  input wire etp_req_t req,
  input wire logic req_ready,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_ready,
  input wire logic busy,
  input wire logic reject,
  input wire logic [31:0] hist_entry0,
  input wire logic [31:0] last_process_tag,
  input wire logic [31:0] last_vm_tag
);
  wire logic [4:0] ty = req.exc_type;
  wire logic take = req_valid && req_ready && ce;
  wire logic ok = (req.elem_sel == 2'h1 || req.elem_sel == 2'h2) &&
    ((ty <= 5'h07 && ty != 5'h05) || ty[4:3] == 2'h2 ||
    (ty >= 5'h0A && ty <= 5'h0F && ty != 5'h0D));
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_hold_byte: assert property (out_valid && !out_ready && ce |=>
    out_valid && $stable(out_data)) else $error("byte changed untaken");
  a_header_first: assert property (take && ok |=>
    out_valid && out_data == 8'h06) else $error("no header byte");
  a_reserved_drop: assert property (take && !ok |=>
    reject && !out_valid && req_ready) else $error("reserved not dropped");
  a_valid_quiet: assert property (take && ok |=> !reject && busy)
    else $error("valid request rejected");
  a_one_packet: assert property (out_valid |-> busy && !req_ready)
    else $error("request open mid packet");
  a_hist_align: assert property (hist_entry0[0] == 1'b0)
    else $error("history bit 0 set");
  a_tag_keep: assert property (!busy |=> $stable(last_process_tag) &&
    $stable(last_vm_tag) && $stable(hist_entry0)) else $error("idle drift");
  a_ready_back: assert property ($fell(busy) |-> req_ready)
    else $error("ready missing after packet");
  a_freeze_hold: assert property (!ce |=> $stable(out_data) &&
    $stable(out_valid) && $stable(busy) && $stable(req_ready) &&
    $stable(hist_entry0)) else $error("state moved while frozen");
endmodule

//--- etp_sink.sv
// Trace sink model that collects packet bytes
`timescale 1ns/1ns
module etp_sink (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic stall,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  output logic out_ready
);
  logic [7:0] got[$];
  logic tog_r;
  // Half-rate take when stalling, so bytes must wait
  assign out_ready = stall ? tog_r : 1'b1;
  always_ff @(posedge clk) begin
    if (rst) tog_r <= 1'b0;
    else tog_r <= ~tog_r;
  end
  always @(posedge clk) begin
    // A frozen encoder takes no byte, so neither does the sink
    if (!rst && ce && out_valid && out_ready) begin
      got.push_back(out_data);
    end
  end
endmodule

//--- tb_etp_encoder.sv
// Self-checking bench for the exception trace packet encoder
`timescale 1ns/1ns
module tb_etp_encoder;
  import etp_pkg::*;
  logic clk, rst, ce, req_valid, stall, req_ready, out_valid, out_ready;
  logic busy, reject;
  etp_req_t req;
  logic [7:0] out_data;
  logic [31:0] hist_entry0, last_process_tag, last_vm_tag, e_pt, e_vt;
  int num_errors, check_count;
  logic [7:0] exp[$];
  etp_encoder u_etp_encoder(.clk, .rst, .ce, .req_valid, .req, .req_ready,
    .out_valid, .out_data, .out_ready, .busy, .reject, .hist_entry0,
    .last_process_tag, .last_vm_tag);
  etp_sink u_etp_sink(.clk, .rst, .ce, .stall, .out_valid, .out_data,
    .out_ready);
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    check_count++;
    if (got !== want) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 99) begin
      chk(n, 0);
      summarize();
    end
  endtask
  function automatic etp_req_t mk(input logic [4:0] t, input logic [1:0] e,
      input logic [1:0] v);
    return '{t, e, v, v[0], v[1], {t, 27'h2BCDEF}, 32'h1234_5678,
      32'hA5C3_0F96, v[1], v[0], 1'b1, 1'b1};
  endfunction
  task automatic send(input etp_req_t r, input logic s, input logic ok);
    logic [31:0] pt, vt, a;
    logic [63:0] hd;
    int n;
    a = r.ret_addr;
    pt = r.process_tag_trace_en ? r.process_tag : 32'h0;
    vt = r.vm_tag_trace_en ? r.virtual_machine_tag : 32'h0;
    // Fixed eight bytes, first byte in the low lane
    hd = {r.send_process_tag, r.send_vm_tag, r.security_state_bit,
      r.execution_width_bit, 2'h0, r.exception_level, a[31:24], a[23:16],
      a[15:8], 1'b0, a[7:1], 8'h83, 1'b0, r.elem_sel[1], r.exc_type,
      r.elem_sel[0], 8'h06};
    exp.delete();
    for (int i = 0; i < 8; i++) exp.push_back(hd[8*i+:8]);
    for (int i = 0; i < 4 && r.send_vm_tag; i++) exp.push_back(vt[8*i+:8]);
    for (int i = 0; i < 4 && r.send_process_tag; i++) exp.push_back(pt[8*i+:8]);
    u_etp_sink.got.delete();
    @(posedge clk);
    req <= r;
    req_valid <= 1'b1;
    stall <= s;
    n = 0;
    do @(posedge clk); while (!req_ready && ++n < 99);
    tmo(n);
    req_valid <= 1'b0;
    if (!ok) begin
      @(negedge clk);
      chk(reject, 1'b1);
      chk(out_valid, 1'b0);
      return;
    end
    n = 0;
    while (u_etp_sink.got.size() < exp.size() && n < 99) begin
      @(posedge clk);
      n++;
    end
    tmo(n);
    @(negedge clk);
    foreach (exp[i]) chk(u_etp_sink.got[i], exp[i]);
    chk(out_valid, 1'b0);
    chk(hist_entry0, {a[31:1], 1'b0});
    if (r.send_process_tag) e_pt = pt;
    if (r.send_vm_tag) e_vt = vt;
    chk(last_process_tag, e_pt);
    chk(last_vm_tag, e_vt);
  endtask
  task automatic t_variants();
    for (int i = 0; i < 4; i++) send(mk(5'h0E, 2'h1, 2'(i)), i[0], 1'b1);
    $display("variants done");
  endtask
  task automatic t_types();
    logic [4:0] t;
    for (int i = 0; i < 32; i++) begin
      t = 5'(i);
      send(mk(t, 2'h2, 2'h0), 1'b0, (t <= 5'h07 && t != 5'h05) ||
        t[4:3] == 2'h2 || (t >= 5'h0A && t <= 5'h0F && t != 5'h0D));
    end
    $display("types done");
  endtask
  task automatic t_esel();
    send(mk(5'h03, 2'h0, 2'h3), 1'b0, 1'b0);
    send(mk(5'h03, 2'h3, 2'h3), 1'b0, 1'b0);
    send(mk(5'h18, 2'h1, 2'h3), 1'b1, 1'b0);
    send(mk(5'h17, 2'h1, 2'h3), 1'b1, 1'b1);
    $display("element codes done");
  endtask
  task automatic t_tags_off();
    etp_req_t r;
    r = mk(5'h0F, 2'h2, 2'h3);
    r.process_tag_trace_en = 1'b0;
    send(r, 1'b1, 1'b1);
    r.process_tag_trace_en = 1'b1;
    r.vm_tag_trace_en = 1'b0;
    send(r, 1'b0, 1'b1);
    send(mk(5'h01, 2'h1, 2'h0), 1'b0, 1'b1);
    $display("tag tracing done");
  endtask
  task automatic t_freeze();
    fork
      send(mk(5'h0E, 2'h1, 2'h3), 1'b1, 1'b1);
      begin
        // Drop enable while bytes are in flight
        repeat (5) @(posedge clk);
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
      end
    join
    $display("freeze done");
  endtask
  task automatic t_reset();
    send(mk(5'h0C, 2'h1, 2'h3), 1'b0, 1'b1);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(req_ready, 1'b0);
    chk(out_valid, 1'b0);
    chk(busy, 1'b0);
    chk(hist_entry0, 32'h0);
    chk(last_process_tag, 32'h0);
    chk(last_vm_tag, 32'h0);
    @(posedge clk);
    rst <= 1'b0;
    e_pt = 32'h0;
    e_vt = 32'h0;
    send(mk(5'h0B, 2'h2, 2'h2), 1'b1, 1'b1);
    $display("reset done");
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    req_valid = 1'b0;
    stall = 1'b0;
    req = '0;
    num_errors = 0;
    check_count = 0;
    e_pt = 32'h0;
    e_vt = 32'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_variants();
    t_types();
    t_esel();
    t_tags_off();
    t_freeze();
    t_reset();
    summarize();
  end
endmodule
bind etp_encoder etp_monitor u_etp_monitor(.clk, .rst, .ce, .req_valid,
  .req, .req_ready, .out_valid, .out_data, .out_ready, .busy, .reject,
  .hist_entry0, .last_process_tag, .last_vm_tag);
